// ---- irq_ctl.sv ----
// two-level vectored interrupt controller for a pipelined core
// assumes peripherals and core sequencer share the system clock
module irq_ctl (
  input  wire logic                       mclk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic [irq_ctl_pkg::N_SRC-1:0] src_event_i,
  input  wire logic [irq_ctl_pkg::N_SRC-1:0] flag_sw_set_i,
  input  wire logic [irq_ctl_pkg::N_SRC-1:0] flag_sw_clr_i,
  input  wire logic                       sfr_wr_i,
  input  wire logic [7:0]                 sfr_addr_i,
  input  wire logic [7:0]                 sfr_wdata_i,
  input  wire logic                       instr_boundary_i,
  input  wire logic                       call_start_i,
  input  wire logic                       ret_done_i,
  output logic [irq_ctl_pkg::N_SRC-1:0]   pend_o,
  output logic [7:0]                      irq_enable_primary_o,
  output logic [7:0]                      irq_priority_primary_o,
  output logic [7:0]                      irq_enable_ext_first_o,
  output logic [7:0]                      irq_enable_ext_second_o,
  output logic [7:0]                      irq_priority_ext_first_o,
  output logic [7:0]                      irq_priority_ext_second_o,
  output logic                            irq_req_o,
  output logic                            irq_hi_o,
  output logic [irq_ctl_pkg::IDX_W-1:0]   irq_src_o,
  output logic [irq_ctl_pkg::VEC_W-1:0]   irq_vector_o,
  output logic                            in_service_hi_o,
  output logic                            in_service_lo_o
);
  import irq_ctl_pkg::*;

  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  logic [7:0]       en_prim_r;
  logic [7:0]       pri_prim_r;
  logic [7:0]       en_ext1_r;
  logic [7:0]       en_ext2_r;
  logic [7:0]       pri_ext1_r;
  logic [7:0]       pri_ext2_r;
  logic [N_SRC-1:0] src_en_w;
  logic [N_SRC-1:0] src_hi_w;
  logic [N_SRC-1:0] qual_w;
  logic [N_SRC-1:0] hw_clr_w;
  logic             glb_en_w;
  logic             hi_ok_w;
  logic             lo_ok_w;
  logic             req_nxt;
  ctl_state_e       state_r;
  logic [2:0]       call_cnt_r;
  logic             act_hi_r;
  logic             act_lo_r;
  logic             req_r;
  logic             hi_r;
  src_idx_t         src_r;
  logic [VEC_W-1:0] vec_r;
  src_idx_t         pick_nxt;
  logic             pick_hi_nxt;

  pick_if hi_pick ();
  pick_if lo_pick ();

  // -------------------------------------------------------------
  // enable and priority registers
  // -------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      en_prim_r <= RST_REG; // see RQ21
      en_ext1_r <= RST_REG;
      en_ext2_r <= RST_REG;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == ADDR_EN_PRIM) begin
        en_prim_r <= sfr_wdata_i; // see RQ21
      end
      if (sfr_addr_i == ADDR_EN_EXT1) begin
        en_ext1_r <= sfr_wdata_i; // see RQ7
      end
      if (sfr_addr_i == ADDR_EN_EXT2) begin
        en_ext2_r <= sfr_wdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pri_prim_r <= RST_REG; // see RQ13
      pri_ext1_r <= RST_REG;
      pri_ext2_r <= RST_REG;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == ADDR_PRI_PRIM) begin
        pri_prim_r <= sfr_wdata_i;
      end
      if (sfr_addr_i == ADDR_PRI_EXT1) begin
        pri_ext1_r <= sfr_wdata_i;
      end
      if (sfr_addr_i == ADDR_PRI_EXT2) begin
        pri_ext2_r <= sfr_wdata_i;
      end
    end
  end

  // -------------------------------------------------------------
  // per-source enable and level mapping
  // -------------------------------------------------------------
  always_comb begin
    src_en_w = '0;
    src_hi_w = '0;
    for (int i = 0; i < PRIM_CNT; i++) begin
      src_en_w[i] = en_prim_r[i]; // see RQ7
      src_hi_w[i] = pri_prim_r[i]; // see RQ1
    end
    for (int i = 0; i < EXT1_CNT; i++) begin
      src_en_w[EXT1_BASE+i] = en_ext1_r[i];
      src_hi_w[EXT1_BASE+i] = pri_ext1_r[i];
    end
    for (int i = 0; i < EXT2_CNT; i++) begin
      src_en_w[EXT2_BASE+i] = en_ext2_r[i];
      src_hi_w[EXT2_BASE+i] = pri_ext2_r[i];
    end
  end

  assign glb_en_w = en_prim_r[GLB_EN_BIT];
  assign qual_w   = glb_en_w ? (pend_o & src_en_w) : '0; // see RQ5 see RQ6

  // -------------------------------------------------------------
  // pending flags
  // -------------------------------------------------------------
  assign hw_clr_w = (call_start_i && req_r) ?
                    (HW_CLR_MASK & (N_SRC'(1) << src_r)) : '0; // see RQ10

  for (genvar g = 0; g < N_SRC; g++) begin : g_flag
    pend_flag u_flag (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .set_i     (src_event_i[g] | flag_sw_set_i[g]), // see RQ2 see RQ12
      .clr_i     (flag_sw_clr_i[g] | hw_clr_w[g]),
      .flag_o    (pend_o[g])
    );
  end

  // -------------------------------------------------------------
  // priority resolution
  // -------------------------------------------------------------
  assign hi_pick.req = qual_w & src_hi_w;
  assign lo_pick.req = qual_w & ~src_hi_w;

  src_picker u_hi_pick (
    .p (hi_pick)
  );

  src_picker u_lo_pick (
    .p (lo_pick)
  );

  assign hi_ok_w = hi_pick.valid && !act_hi_r; // see RQ14
  assign lo_ok_w = lo_pick.valid && !act_hi_r && !act_lo_r; // see RQ20

  always_comb begin
    pick_hi_nxt = hi_ok_w; // see RQ15
    pick_nxt    = hi_ok_w ? hi_pick.idx : lo_pick.idx;
    req_nxt     = (state_r == ST_READY) && !call_start_i && !ret_done_i // see RQ18
                  && (hi_ok_w || lo_ok_w); // see RQ16
  end

  // -------------------------------------------------------------
  // sequencing state
  // -------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_r    <= ST_READY;
      call_cnt_r <= 3'h0;
    end else begin
      case (state_r)
        ST_READY: begin
          if (call_start_i) begin
            state_r    <= ST_CALL; // see RQ3
            call_cnt_r <= 3'h0;
          end else if (ret_done_i) begin
            state_r <= ST_HOLD; // see RQ18
          end
        end
        ST_CALL: begin
          call_cnt_r <= call_cnt_r + 3'h1;
          if (call_cnt_r == CALL_LAST) begin
            state_r <= ST_READY; // see RQ17
          end
        end
        ST_HOLD: begin
          if (instr_boundary_i) begin
            state_r <= ST_READY; // see RQ11 see RQ19
          end
        end
        default: begin
          state_r <= ST_READY;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // service level tracking
  // -------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      act_hi_r <= 1'b0;
      act_lo_r <= 1'b0;
    end else if (call_start_i && req_r) begin
      if (hi_r) begin
        act_hi_r <= 1'b1; // see RQ23
      end else begin
        act_lo_r <= 1'b1;
      end
    end else if (ret_done_i) begin
      if (act_hi_r) begin
        act_hi_r <= 1'b0; // see RQ4
      end else begin
        act_lo_r <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // request and vector to the core
  // -------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      req_r <= 1'b0;
      hi_r  <= 1'b0;
      src_r <= '0;
      vec_r <= VEC_BASE;
    end else begin
      req_r <= req_nxt; // see RQ8 see RQ17
      if (req_nxt) begin
        hi_r  <= pick_hi_nxt;
        src_r <= pick_nxt;
        vec_r <= VEC_BASE + (VEC_W'(pick_nxt) << VEC_SHIFT); // see RQ22
      end
    end
  end

  assign irq_enable_primary_o      = en_prim_r;
  assign irq_priority_primary_o    = pri_prim_r;
  assign irq_enable_ext_first_o    = en_ext1_r;
  assign irq_enable_ext_second_o   = en_ext2_r;
  assign irq_priority_ext_first_o  = pri_ext1_r;
  assign irq_priority_ext_second_o = pri_ext2_r;
  assign irq_req_o                 = req_r;
  assign irq_hi_o                  = hi_r;
  assign irq_src_o                 = src_r;
  assign irq_vector_o              = vec_r;
  assign in_service_hi_o           = act_hi_r;
  assign in_service_lo_o           = act_lo_r;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  chk_flag_sets: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ2
    (|(src_event_i | flag_sw_set_i)) |=>
      ((pend_o & $past(src_event_i | flag_sw_set_i)) == $past(src_event_i | flag_sw_set_i)))
    else $error("pending flag not set by event");

  chk_global_gate: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ6
    !glb_en_w |=> !req_r)
    else $error("request without global enable");

  chk_disabled_quiet: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ5
    ((pend_o & src_en_w) == '0) |=> !req_r)
    else $error("request from disabled source");

  chk_detect_one: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ17
    (state_r == ST_READY && !call_start_i && !ret_done_i && !act_hi_r && !act_lo_r && |qual_w) |=> req_r)
    else $error("request not raised after one clock");

  chk_call_len: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ17
    (state_r == ST_READY && call_start_i) |=> (state_r == ST_CALL)[*4] ##1 (state_r == ST_READY))
    else $error("vector call window not four clocks");

  chk_hi_no_preempt: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ14
    act_hi_r |=> !req_r)
    else $error("high routine preempted");

  chk_hw_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ10
    (call_start_i && req_r && HW_CLR_MASK[src_r] && !src_event_i[src_r] && !flag_sw_set_i[src_r])
      |=> !pend_o[$past(src_r)])
    else $error("flag not cleared at vector call");

  chk_hold_one: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ18
    (state_r == ST_HOLD) |=> !req_r)
    else $error("call before one further instruction");

  chk_hi_first: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ15
    (state_r == ST_READY && !call_start_i && hi_ok_w) |=>
      (req_r && hi_r && src_r == $past(hi_pick.idx)))
    else $error("high priority source not chosen");

  chk_vector_map: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ22
    req_r |-> (vec_r == VEC_BASE + (VEC_W'(src_r) << VEC_SHIFT)))
    else $error("vector does not match source");

  chk_ret_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ18
    (state_r == ST_READY && ret_done_i && !call_start_i) |=> (state_r == ST_HOLD && !req_r))
    else $error("return not followed by hold");

  chk_hold_release: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ19
    (state_r == ST_HOLD && instr_boundary_i) |=> (state_r == ST_READY))
    else $error("hold not left at instruction end");

  chk_lo_waits: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ20
    (act_lo_r && !hi_ok_w) |=> !req_r)
    else $error("low request while low routine runs");

  chk_req_drops: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ3
    (call_start_i && req_r) |=> !req_r)
    else $error("request held after vector call");

  chk_mark_hi: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ23
    (call_start_i && req_r && hi_r) |=> act_hi_r)
    else $error("high level not marked in service");

  chk_mark_lo: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ23
    (call_start_i && req_r && !hi_r) |=> act_lo_r)
    else $error("low level not marked in service");

  chk_ret_level: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ4
    (ret_done_i && !(call_start_i && req_r) && act_hi_r) |=> !act_hi_r)
    else $error("high level kept after return");

  chk_flag_kept: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see RQ10
    (call_start_i && req_r && !HW_CLR_MASK[src_r] && pend_o[src_r] && !flag_sw_clr_i[src_r])
      |=> pend_o[$past(src_r)])
    else $error("software-cleared flag lost at vector call");

  cov_call: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    req_r && call_start_i);

  cov_preempt: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    act_lo_r && req_r && hi_r && call_start_i);

  cov_reenter: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_r == ST_HOLD) ##[1:20] req_r);

  cov_late_req: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    req_r && !glb_en_w);

endmodule

// ---- irq_ctl_pkg.sv ----
// constants, types and addresses of the two-level vectored interrupt controller
// assumes one system clock and a synchronous active-high core reset
//
// Function
// RQ1 - eighteen sources, each set to low or high priority
// RQ2 - a source event sets its pending flag whether enabled or not
// RQ3 - enabled pending source raises a request; core calls its vector after current instruction
// RQ4 - return-from-interrupt resumes the interrupted program; core keeps the return point
// RQ5 - pending flag of a disabled source gives no request
// RQ6 - source enables act only while global enable is one
// RQ7 - each source has its own enable bit in one of three enable registers
// RQ8 - request seen while an enable clears may still be taken before a single-cycle instruction
// RQ9 - software follows an enable-clearing instruction with a two-byte instruction
// RQ10 - some flags clear by hardware at the vector call; others stay set
// RQ11 - a flag still set after return raises a new request at once; the code first waits in ST_HOLD for one instruction boundary
// RQ12 - software writing one to a flag acts like a hardware event
// RQ13 - each source has a priority bit in three registers, resetting to low
// RQ14 - high preempts a running low routine; a high routine is never preempted
// RQ15 - same-cycle requests: higher priority first, then fixed source order
// RQ16 - requests sampled and resolved on every clock
// RQ17 - least response five clocks: one to detect, four for the call
// RQ18 - after a return one further instruction runs before the next call
// RQ19 - worst response eighteen clocks: detect, return, divide, call
// RQ20 - request waits while equal or higher routine runs, until return plus one instruction
// RQ21 - primary enable register at 0xa8, global enable on top bit, resets zero
// RQ22 - lowest source index wins a tie; its vector goes to the core
// RQ23 - core flags call start and return completion so service level is tracked
package irq_ctl_pkg;

  // -------------------------------------------------------------
  // sources and vectors
  // -------------------------------------------------------------
  localparam int          N_SRC         = 18;
  localparam int          IDX_W         = 5;
  localparam int          VEC_W         = 16;
  localparam logic [15:0] VEC_BASE      = 16'h0003;
  localparam int          VEC_SHIFT     = 3;
  localparam logic [17:0] HW_CLR_MASK   = 18'h1000f;

  // -------------------------------------------------------------
  // special-register addresses
  // -------------------------------------------------------------
  localparam logic [7:0]  ADDR_EN_PRIM  = 8'ha8;
  localparam logic [7:0]  ADDR_PRI_PRIM = 8'hb8;
  localparam logic [7:0]  ADDR_EN_EXT1  = 8'he6;
  localparam logic [7:0]  ADDR_EN_EXT2  = 8'he7;
  localparam logic [7:0]  ADDR_PRI_EXT1 = 8'hf6;
  localparam logic [7:0]  ADDR_PRI_EXT2 = 8'hf7;
  localparam logic [7:0]  RST_REG       = 8'h00;

  // -------------------------------------------------------------
  // field layout
  // -------------------------------------------------------------
  localparam int          GLB_EN_BIT    = 7;
  localparam int          PRIM_CNT      = 7;
  localparam int          EXT1_BASE     = 7;
  localparam int          EXT1_CNT      = 8;
  localparam int          EXT2_BASE     = 15;
  localparam int          EXT2_CNT      = 3;

  // -------------------------------------------------------------
  // timing in system clocks
  // -------------------------------------------------------------
  localparam int          DETECT_CYC    = 1;
  localparam int          CALL_CYC      = 4;
  localparam int          RET_CYC       = 5;
  localparam int          DIV_CYC       = 8;
  localparam int          MIN_RESP_CYC  = DETECT_CYC + CALL_CYC;
  localparam int          MAX_RESP_CYC  = DETECT_CYC + RET_CYC + DIV_CYC + CALL_CYC;
  localparam logic [2:0]  CALL_LAST     = 3'(CALL_CYC - 1);

  typedef logic [IDX_W-1:0] src_idx_t;

  typedef enum logic [1:0] {
    ST_READY = 2'b00,
    ST_CALL  = 2'b01,
    ST_HOLD  = 2'b11
  } ctl_state_e;

endpackage

// ---- pick_if.sv ----
// request vector and winning source between the controller and a picker
// assumes the picker answers combinationally in the same cycle
interface pick_if;
  import irq_ctl_pkg::*;
  logic [N_SRC-1:0] req;
  logic             valid;
  src_idx_t         idx;
  modport picker (input req, output valid, output idx);
  modport user   (output req, input valid, input idx);
endinterface

// ---- pend_flag.sv ----
// one sticky pending flag
// assumes set and clear inputs on the system clock
module pend_flag (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  // -------------------------------------------------------------
  // flag store, set wins over clear
  // -------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1; // see RQ2
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end

endmodule

// ---- src_picker.sv ----
// fixed-order picker: lowest requesting index wins
// assumes a request vector from the controller
module src_picker (
  pick_if.picker p
);
  import irq_ctl_pkg::*;

  // -------------------------------------------------------------
  // lowest index search
  // -------------------------------------------------------------
  always_comb begin
    p.valid = 1'b0;
    p.idx   = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (p.req[i]) begin
        p.valid = 1'b1; // see RQ22
        p.idx   = IDX_W'(i);
      end
    end
  end

endmodule

// ---- core_model.sv ----
// behavioural instruction sequencer facing the interrupt controller
// assumes the bench sets instruction length and call acceptance
module core_model (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [3:0] instr_len_i,
  input  wire logic       accept_i,
  input  wire logic       ret_cmd_i,
  input  wire logic       irq_req_i,
  output logic            instr_boundary_o,
  output logic            call_start_o,
  output logic            ret_done_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // instruction pacing
  // ----------------------------------------
  logic [3:0] cnt_r;
  logic [2:0] win_r;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_r <= 4'h0;
      win_r <= 3'h0;
    end else if (call_start_o) begin
      win_r <= 3'h4;
      cnt_r <= 4'h0;
    end else if (win_r != 3'h0) begin
      win_r <= win_r - 3'h1;
    end else if (instr_boundary_o) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  assign instr_boundary_o = (win_r == 3'h0) && (cnt_r == instr_len_i - 4'h1);

  // ----------------------------------------
  // call and return
  // ----------------------------------------
  // call only as an instruction completes
  assign call_start_o = accept_i & irq_req_i & instr_boundary_o;
  // return completion passed straight through from ret_cmd_i
  assign ret_done_o   = ret_cmd_i;
endmodule

// ---- tb_top.sv ----
// self-checking bench for the interrupt controller
// assumes core_model stands in for the instruction sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_ctl_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic             mclk_i = 1'b0;
  logic             sys_rst_i = 1'b1;
  logic [N_SRC-1:0] src_event_i = '0;
  logic [N_SRC-1:0] flag_sw_set_i = '0;
  logic [N_SRC-1:0] flag_sw_clr_i = '0;
  logic             sfr_wr_i = 1'b0;
  logic [7:0]       sfr_addr_i = 8'h00;
  logic [7:0]       sfr_wdata_i = 8'h00;
  logic [3:0]       instr_len = 4'h1;
  logic             accept = 1'b0;
  logic             ret_cmd = 1'b0;
  logic             instr_boundary, call_start, ret_done;
  logic [N_SRC-1:0] pend;
  logic [7:0]       en0, pr0, e1, e2, p1, p2;
  logic             req, hi, sv_hi, sv_lo;
  logic [IDX_W-1:0] src;
  logic [VEC_W-1:0] vec;
  int               n_mismatch = 0;
  int               tests_run = 0;
  int               k;

  typedef struct {
    logic [47:0]      regs;
    logic [N_SRC-1:0] ev;
    logic [N_SRC-1:0] sw;
    logic             req;
    logic             hi;
    logic [IDX_W-1:0] src;
  } row_s;
  row_s rows [7];

  always #12.5 mclk_i = ~mclk_i;

  irq_ctl DUT (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .src_event_i(src_event_i),
    .flag_sw_set_i(flag_sw_set_i), .flag_sw_clr_i(flag_sw_clr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .instr_boundary_i(instr_boundary),
    .call_start_i(call_start), .ret_done_i(ret_done), .pend_o(pend),
    .irq_enable_primary_o(en0), .irq_priority_primary_o(pr0), .irq_enable_ext_first_o(e1),
    .irq_enable_ext_second_o(e2), .irq_priority_ext_first_o(p1), .irq_priority_ext_second_o(p2),
    .irq_req_o(req), .irq_hi_o(hi), .irq_src_o(src), .irq_vector_o(vec),
    .in_service_hi_o(sv_hi), .in_service_lo_o(sv_lo)
  );

  core_model core (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .instr_len_i(instr_len), .accept_i(accept),
    .ret_cmd_i(ret_cmd), .irq_req_i(req), .instr_boundary_o(instr_boundary),
    .call_start_o(call_start), .ret_done_o(ret_done)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chk_val(input string nm, input logic [47:0] exp, input logic [47:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sfr_wr_i <= 1'b1;
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    @(posedge mclk_i);
    sfr_wr_i <= 1'b0;
  endtask

  task automatic set_regs(input logic [47:0] r);
    wr(ADDR_EN_PRIM, r[47:40]);
    wr(ADDR_PRI_PRIM, r[39:32]);
    wr(ADDR_EN_EXT1, r[31:24]);
    wr(ADDR_EN_EXT2, r[23:16]);
    wr(ADDR_PRI_EXT1, r[15:8]);
    wr(ADDR_PRI_EXT2, r[7:0]);
    @(posedge mclk_i);
    #1;
    chk_val("registers", r, {en0, pr0, e1, e2, p1, p2});
  endtask

  task automatic pulse(input logic [N_SRC-1:0] ev, input logic [N_SRC-1:0] sw, input logic [N_SRC-1:0] clr);
    @(posedge mclk_i);
    src_event_i <= ev;
    flag_sw_set_i <= sw;
    flag_sw_clr_i <= clr;
    @(posedge mclk_i);
    src_event_i <= '0;
    flag_sw_set_i <= '0;
    flag_sw_clr_i <= '0;
  endtask

  task automatic ret_irq();
    @(posedge mclk_i);
    ret_cmd <= 1'b1;
    @(posedge mclk_i);
    ret_cmd <= 1'b0;
  endtask

  task automatic wait_call(output int n);
    n = 1;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
      if (n > 60) begin
        n_mismatch++;
        $display("unexpected call wait: expected call seen none");
        close_out();
      end
    end while (call_start !== 1'b1);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    rows[0] = '{48'h010000000000, 18'h00001, 18'h0, 1'b0, 1'b0, 5'h00};
    rows[1] = '{48'h800000000000, 18'h00002, 18'h0, 1'b0, 1'b0, 5'h00};
    rows[2] = '{48'ha10000000000, 18'h00021, 18'h0, 1'b1, 1'b0, 5'h00};
    rows[3] = '{48'ha12000000000, 18'h00021, 18'h0, 1'b1, 1'b1, 5'h05};
    rows[4] = '{48'h800080040004, 18'h24000, 18'h0, 1'b1, 1'b1, 5'h11};
    rows[5] = '{48'h800004000000, 18'h0, 18'h00200, 1'b1, 1'b0, 5'h09};
    rows[6] = '{48'h800001010100, 18'h08080, 18'h0, 1'b1, 1'b1, 5'h07};
    repeat (20) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk_val("reset registers", 48'h0, {en0, pr0, e1, e2, p1, p2});
    chk_val("reset vector", 48'(VEC_BASE), 48'(vec));
    chk_bit("reset request", 1'b0, req);
    done("reset");
    foreach (rows[i]) begin
      set_regs(rows[i].regs);
      pulse(rows[i].ev, rows[i].sw, '0);
      repeat (2) @(posedge mclk_i);
      #1;
      chk_val("pending", 48'(rows[i].ev | rows[i].sw), 48'(pend));
      chk_bit("request", rows[i].req, req);
      if (rows[i].req) begin
        chk_bit("level", rows[i].hi, hi);
        chk_val("source", 48'(rows[i].src), 48'(src));
        chk_val("vector", 48'(VEC_BASE + (16'(rows[i].src) << VEC_SHIFT)), 48'(vec));
      end
      pulse('0, '0, '1);
      set_regs(48'h0);
      done("table row");
    end
    @(posedge mclk_i);
    accept <= 1'b1;
    set_regs(48'h910000000000);
    pulse(18'h00011, '0, '0);
    wait_call(k);
    chk_val("response edges", 48'd2, 48'(k));
    chk_val("first source", 48'h0, 48'(src));
    @(posedge mclk_i);
    #1;
    chk_bit("low in service", 1'b1, sv_lo);
    chk_val("pending after call", 48'h10, 48'(pend));
    repeat (8) @(posedge mclk_i);
    #1;
    chk_bit("request while low runs", 1'b0, req);
    ret_irq();
    #1;
    chk_bit("request in hold", 1'b0, req);
    wait_call(k);
    chk_val("reentry source", 48'h4, 48'(src));
    done("response and return");
    wr(ADDR_PRI_PRIM, 8'h60);
    wr(ADDR_EN_PRIM, 8'hf1);
    @(posedge mclk_i);
    instr_len <= 4'h8;
    pulse(18'h00020, '0, '0);
    wait_call(k);
    chk_bit("worst response", 1'b1, k <= MAX_RESP_CYC);
    chk_bit("preempt level", 1'b1, hi);
    pulse(18'h00040, '0, '0);
    repeat (12) @(posedge mclk_i);
    #1;
    chk_bit("high in service", 1'b1, sv_hi);
    chk_bit("request while high runs", 1'b0, req);
    pulse('0, '0, 18'h00020);
    ret_irq();
    wait_call(k);
    chk_val("after high return", 48'h6, 48'(src));
    pulse('0, '0, '1);
    repeat (20) @(posedge mclk_i);
    ret_irq();
    repeat (20) @(posedge mclk_i);
    ret_irq();
    repeat (20) @(posedge mclk_i);
    done("preemption");
    accept <= 1'b0;
    instr_len <= 4'h2;
    set_regs(48'h820000000000);
    pulse(18'h00002, '0, '0);
    repeat (2) @(posedge mclk_i);
    #1;
    chk_bit("request before clear", 1'b1, req);
    // next software instruction two bytes long
    wr(ADDR_EN_PRIM, 8'h02);
    #1;
    chk_bit("late request", 1'b1, req);
    @(posedge mclk_i);
    #1;
    chk_bit("request after clear", 1'b0, req);
    wr(8'ha9, 8'hff);
    @(posedge mclk_i);
    #1;
    chk_val("unmapped write", 48'h020000000000, {en0, pr0, e1, e2, p1, p2});
    done("enable clear");
    close_out();
  end
endmodule
